/* File: cmpc_top.sv */
// comparator control and status register bank with output filter and timer routing
// Function
// (RULE_01) enable bit gates interrupt request
// (RULE_02) flag cleared by writing zero only
// (RULE_03) lock bit writable once per reset
// (RULE_04) lock freezes control, filter, prescaler
// (RULE_05) control bit 17 shows comparator output
// (RULE_06) bit 14 masks output with timer blank
// (RULE_07) bits 13:12 drive hysteresis level
// (RULE_08) bit 11 inverts comparator output
// (RULE_09) bits 9:7 route output to timer
// (RULE_10) bits 4:3 select positive offset
// (RULE_11) bit 2 selects positive input pin
// (RULE_12) bit 1 selects negative input pin
// (RULE_13) bit 0 switches comparator on
// (RULE_14) software keeps reserved bits at reset
// (RULE_15) filter window field, filter enable bit
// (RULE_16) threshold above half the window field
// (RULE_17) prescaler sets sample every value+1 clocks
// (RULE_18) interrupt on output going high
// (RULE_19) filtered level changes on threshold agreement
// (RULE_20) flag set on processed output rising edge
`timescale 1ns/1ns
`default_nettype none
module cmpc_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic analog_compare_out,
    input wire logic advanced_timer_blank,
    output logic comparator_enable,
    output logic negative_input_select,
    output logic positive_input_select,
    output logic [1:0] positive_offset_select,
    output logic [1:0] hysteresis_level,
    output logic advanced_timer_break_input,
    output logic advanced_timer_capture_one,
    output logic advanced_timer_ref_clear,
    output logic general_timer_capture_one,
    output logic general_timer_ref_clear,
    output logic irq_request
);
    ////////////////////////////////////////////////////////////////////////////////
    // bus write channel
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic ar_valid_q, ar_valid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    logic [31:0] control_q, control_d;
    logic [31:0] filter_q, filter_d;
    logic [31:0] prescale_q, prescale_d;
    logic irq_enable_q, irq_enable_d;
    logic irq_flag_q, irq_flag_d;
    logic lock_q, lock_d;
    logic lock_written_q, lock_written_d;

    // byte-lane merge limited to the writable bits
    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        merge_strb = (old & ~m) | (wd & m);
    endfunction

    // offsets that answer with an okay response
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == cmpc_pkg::OFS_IRQ_ENABLE) || (a == cmpc_pkg::OFS_IRQ_FLAG) ||
                     (a == cmpc_pkg::OFS_CONFIG_LOCK) || (a == cmpc_pkg::OFS_CONTROL) ||
                     (a == cmpc_pkg::OFS_FILTER_CONTROL) || (a == cmpc_pkg::OFS_FILTER_PRESCALE);
    endfunction

    wire logic [7:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire logic [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    // either channel may come first; the early one is parked
    wire logic aw_here = aw_held_q | s_axi_awvalid;
    wire logic w_here = w_held_q | s_axi_wvalid;
    wire logic wr_fire = aw_here & w_here & ~bvalid_q;
    wire logic wr_lane0 = wr_strb[0];

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;

    wire logic hit_enable = wr_fire & (wr_addr == cmpc_pkg::OFS_IRQ_ENABLE);
    wire logic hit_flag = wr_fire & (wr_addr == cmpc_pkg::OFS_IRQ_FLAG);
    wire logic hit_lock = wr_fire & (wr_addr == cmpc_pkg::OFS_CONFIG_LOCK);
    wire logic cfg_open = ~lock_q; // [RULE_04]
    wire logic hit_ctl = wr_fire & cfg_open & (wr_addr == cmpc_pkg::OFS_CONTROL);
    wire logic hit_fil = wr_fire & cfg_open & (wr_addr == cmpc_pkg::OFS_FILTER_CONTROL);
    wire logic hit_psc = wr_fire & cfg_open & (wr_addr == cmpc_pkg::OFS_FILTER_PRESCALE);

    ////////////////////////////////////////////////////////////////////////////////
    // output path: polarity, blanking, filter
    logic [15:0] psc_cnt_q, psc_cnt_d;
    logic [31:0] hist_q, hist_d;
    logic [5:0] fill_q, fill_d;
    logic filt_q, filt_d;
    logic out_prev_q;

    wire logic [4:0] win_field = filter_q[cmpc_pkg::FIL_WINDOW_LSB +: 5];
    wire logic [4:0] thresh = filter_q[cmpc_pkg::FIL_THRESH_LSB +: 5];
    wire logic fil_en = filter_q[cmpc_pkg::FIL_ENABLE_BIT]; // [RULE_15]
    wire logic [5:0] win_len = {1'b0, win_field} + 6'h01; // [RULE_15]
    wire logic inverted = analog_compare_out ^ control_q[cmpc_pkg::CTL_INVERT_BIT]; // [RULE_08]
    wire logic blanked = control_q[cmpc_pkg::CTL_BLANK_BIT] ? (inverted & ~advanced_timer_blank)
                                                             : inverted; // [RULE_06]
    // a divider value of n gives one sample every n+1 clocks
    wire logic sample_tick = (psc_cnt_q >= prescale_q[15:0]); // [RULE_17]
    wire logic [31:0] win_mask = (32'h0000_0001 << win_len) - 32'h0000_0001;
    wire logic [31:0] hist_shift = {hist_q[30:0], blanked} & win_mask;
    // ones among the samples of the current window
    logic [5:0] ones_cnt;
    always_comb begin
        ones_cnt = 6'h00;
        for (int i = 0; i < 32; i++) begin
            ones_cnt = ones_cnt + {5'h00, hist_shift[i]};
        end
    end
    wire logic [5:0] fill_next = (fill_q < win_len) ? fill_q + 6'h01 : win_len;
    wire logic [5:0] zeros_cnt = fill_next - ones_cnt;
    wire logic out_level = fil_en ? filt_q : blanked;
    wire logic out_rise = out_level & ~out_prev_q; // [RULE_20]

    always_comb begin
        psc_cnt_d = sample_tick ? 16'h0000 : psc_cnt_q + 16'h0001;
        hist_d = hist_q;
        fill_d = fill_q;
        filt_d = filt_q;
        if (!fil_en) begin
            // stale samples must not count once re-enabled
            hist_d = 32'h0000_0000;
            fill_d = 6'h00;
            filt_d = blanked;
        end else if (sample_tick) begin
            hist_d = hist_shift;
            fill_d = fill_next;
            if (!filt_q && ones_cnt >= {1'b0, thresh}) begin
                filt_d = 1'b1; // [RULE_19]
            end else if (filt_q && zeros_cnt >= {1'b0, thresh}) begin
                filt_d = 1'b0; // [RULE_19]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register next values
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = addr_known(wr_addr) ? cmpc_pkg::RESP_OKAY : cmpc_pkg::RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        irq_enable_d = (hit_enable && wr_lane0) ? wr_data[0] : irq_enable_q;
        lock_d = lock_q;
        lock_written_d = lock_written_q;
        // a zero written as the one lock write spends it too
        if (hit_lock && wr_lane0 && !lock_written_q) begin
            lock_d = wr_data[0]; // [RULE_03]
            lock_written_d = 1'b1; // [RULE_03]
        end
        control_d = hit_ctl ? merge_strb(control_q, wr_data, wr_strb, cmpc_pkg::CTL_WRITE_MASK) : control_q;
        filter_d = hit_fil ? merge_strb(filter_q, wr_data, wr_strb, cmpc_pkg::FIL_WRITE_MASK) : filter_q;
        prescale_d = hit_psc ? merge_strb(prescale_q, wr_data, wr_strb, cmpc_pkg::PSC_WRITE_MASK) : prescale_q;
        irq_flag_d = irq_flag_q;
        if (hit_flag && wr_lane0 && !wr_data[0]) begin
            irq_flag_d = 1'b0; // [RULE_02]
        end
        // a rise in the clearing cycle wins over the clear
        if (out_rise) begin
            irq_flag_d = 1'b1; // [RULE_18] [RULE_20]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel
    // reserved bits read zero; bit 17 is the live processed level
    wire logic [31:0] ctl_view = (control_q & cmpc_pkg::CTL_WRITE_MASK) |
                                 ({31'h0, out_level} << cmpc_pkg::CTL_OUT_BIT); // [RULE_05]
    // unmapped offsets read zero with an error response
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            cmpc_pkg::OFS_IRQ_ENABLE: rd_word = {31'h0, irq_enable_q};
            cmpc_pkg::OFS_IRQ_FLAG: rd_word = {31'h0, irq_flag_q};
            cmpc_pkg::OFS_CONFIG_LOCK: rd_word = {31'h0, lock_q};
            cmpc_pkg::OFS_CONTROL: rd_word = ctl_view;
            cmpc_pkg::OFS_FILTER_CONTROL: rd_word = filter_q;
            cmpc_pkg::OFS_FILTER_PRESCALE: rd_word = prescale_q;
            default: rd_word = 32'h0000_0000;
        endcase
    end
    assign s_axi_arready = ~ar_valid_q;
    always_comb begin
        ar_valid_d = ar_valid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && !ar_valid_q) begin
            ar_valid_d = 1'b1;
            rdata_d = rd_word;
            rresp_d = addr_known(s_axi_araddr) ? cmpc_pkg::RESP_OKAY : cmpc_pkg::RESP_SLVERR;
        end else if (ar_valid_q && s_axi_rready) begin
            ar_valid_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flip-flops: write channel
    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // flip-flops: read channel
    always_ff @(posedge mclk) begin
        if (rst) begin
            ar_valid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else begin
            ar_valid_q <= ar_valid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // flip-flops: register bank
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_enable_q <= 1'b0;
            irq_flag_q <= 1'b0;
            lock_q <= 1'b0; // [RULE_03]
            lock_written_q <= 1'b0;
            control_q <= cmpc_pkg::RST_CONTROL;
            filter_q <= cmpc_pkg::RST_FILTER;
            prescale_q <= cmpc_pkg::RST_PRESCALE;
        end else begin
            irq_enable_q <= irq_enable_d;
            irq_flag_q <= irq_flag_d;
            lock_q <= lock_d;
            lock_written_q <= lock_written_d;
            control_q <= control_d;
            filter_q <= filter_d;
            prescale_q <= prescale_d;
        end
    end

    // flip-flops: output filter and edge detector
    always_ff @(posedge mclk) begin
        if (rst) begin
            psc_cnt_q <= 16'h0000;
            hist_q <= 32'h0000_0000;
            fill_q <= 6'h00;
            filt_q <= 1'b0;
            out_prev_q <= 1'b0;
        end else begin
            psc_cnt_q <= psc_cnt_d;
            hist_q <= hist_d;
            fill_q <= fill_d;
            filt_q <= filt_d;
            out_prev_q <= out_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    // route codes 0, 6 and 7 reach no timer input
    wire logic [2:0] route = control_q[cmpc_pkg::CTL_ROUTE_LSB +: 3];
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = ar_valid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign comparator_enable = control_q[cmpc_pkg::CTL_ENABLE_BIT]; // [RULE_13]
    assign negative_input_select = control_q[cmpc_pkg::CTL_NEG_SEL_BIT]; // [RULE_12]
    assign positive_input_select = control_q[cmpc_pkg::CTL_POS_SEL_BIT]; // [RULE_11]
    assign positive_offset_select = control_q[cmpc_pkg::CTL_OFFSET_LSB +: 2]; // [RULE_10]
    assign hysteresis_level = control_q[cmpc_pkg::CTL_HYST_LSB +: 2]; // [RULE_07]
    assign advanced_timer_break_input = out_level & (route == cmpc_pkg::ROUTE_ADV_BREAK); // [RULE_09]
    assign advanced_timer_capture_one = out_level & (route == cmpc_pkg::ROUTE_ADV_CAPTURE); // [RULE_09]
    assign advanced_timer_ref_clear = out_level & (route == cmpc_pkg::ROUTE_ADV_CLEAR); // [RULE_09]
    assign general_timer_capture_one = out_level & (route == cmpc_pkg::ROUTE_GEN_CAPTURE); // [RULE_09]
    assign general_timer_ref_clear = out_level & (route == cmpc_pkg::ROUTE_GEN_CLEAR); // [RULE_09]
    assign irq_request = irq_flag_q & irq_enable_q; // [RULE_01]
endmodule
`default_nettype wire

/* File: cmpc_pkg.sv */
// package: register map, field positions and reset values of the comparator control block
package cmpc_pkg;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h04;
    localparam logic [7:0] OFS_CONFIG_LOCK = 8'h0c;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_FILTER_CONTROL = 8'h14;
    localparam logic [7:0] OFS_FILTER_PRESCALE = 8'h18;
    // control register fields
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_NEG_SEL_BIT = 1;
    localparam int CTL_POS_SEL_BIT = 2;
    localparam int CTL_OFFSET_LSB = 3;
    localparam int CTL_ROUTE_LSB = 7;
    localparam int CTL_INVERT_BIT = 11;
    localparam int CTL_HYST_LSB = 12;
    localparam int CTL_BLANK_BIT = 14;
    localparam int CTL_OUT_BIT = 17;
    // writable control bits: 14:11, 9:7, 4:0
    localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_7b9f;
    // filter control fields
    localparam int FIL_ENABLE_BIT = 0;
    localparam int FIL_THRESH_LSB = 1;
    localparam int FIL_WINDOW_LSB = 6;
    localparam logic [31:0] FIL_WRITE_MASK = 32'h0000_07ff;
    localparam logic [31:0] PSC_WRITE_MASK = 32'h0000_ffff;
    // reset values
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RST_FILTER = 32'h0000_0000;
    localparam logic [31:0] RST_PRESCALE = 32'h0000_0000;
    // timer route codes
    localparam logic [2:0] ROUTE_ADV_BREAK = 3'h1;
    localparam logic [2:0] ROUTE_ADV_CAPTURE = 3'h2;
    localparam logic [2:0] ROUTE_ADV_CLEAR = 3'h3;
    localparam logic [2:0] ROUTE_GEN_CAPTURE = 3'h4;
    localparam logic [2:0] ROUTE_GEN_CLEAR = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: cmpc_top_chk.sv */
// checker: bus handshakes and output relations of the comparator control block
`timescale 1ns/1ns
`default_nettype none
module cmpc_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_enable,
    input wire logic negative_input_select,
    input wire logic positive_input_select,
    input wire logic [1:0] positive_offset_select,
    input wire logic [1:0] hysteresis_level,
    input wire logic advanced_timer_break_input,
    input wire logic advanced_timer_capture_one,
    input wire logic advanced_timer_ref_clear,
    input wire logic general_timer_capture_one,
    input wire logic general_timer_ref_clear,
    input wire logic irq_request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic [6:0] cfg = {comparator_enable, negative_input_select, positive_input_select,
        positive_offset_select, hysteresis_level};
    wire logic [4:0] route = {advanced_timer_break_input, advanced_timer_capture_one,
        advanced_timer_ref_clear, general_timer_capture_one, general_timer_ref_clear};
    ////////////////////////////////////////////////////////////////////////////////
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write not answered next cycle");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    chk_route_single: assert property ($onehot0(route))
        else $error("more than one timer input driven");
    chk_reset_clear: assert property ($past(rst) |-> cfg == 7'h0 && route == 5'h0 && !irq_request)
        else $error("outputs not cleared by reset");
    chk_config_write: assert property (!$stable(cfg) |-> $rose(s_axi_bvalid))
        else $error("configuration changed without a write");
    chk_irq_clear: assert property ($fell(irq_request) |-> $rose(s_axi_bvalid))
        else $error("interrupt request dropped without a write");
endmodule
bind cmpc_top cmpc_chk u_chk (.*);
`default_nettype wire

/* File: test_comparator_control_regs.sv */
// testbench: register bank, routing, interrupt, filter and lock of the comparator block
`timescale 1ns/1ns
`default_nettype none
module test_comparator_control_regs;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, analog_compare_out = 1'h0, advanced_timer_blank = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, positive_offset_select, hysteresis_level;
    logic [31:0] s_axi_rdata, v;
    logic comparator_enable, negative_input_select, positive_input_select, irq_request;
    logic advanced_timer_break_input, advanced_timer_capture_one, advanced_timer_ref_clear;
    logic general_timer_capture_one, general_timer_ref_clear;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    cmpc_top uut (.*);
    initial begin
        forever #10 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        bq.push_back(r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        rq.push_back({r, d});
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'h0;
    endtask
    // response watcher and hang limit
    always @(posedge mclk) begin
        cycles++;
        if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        v = $urandom(90430);
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0, (i == 2) ? 2'h2 : 2'h0);
        wr(8'h08, 32'hffff_ffff, 2'h2);
        // random words with reserved bits kept at zero, bit 17 shows the inverted low input
        repeat (4) begin
            v = $urandom() & cmpc_pkg::CTL_WRITE_MASK;
            wr(8'h10, v);
            rd(8'h10, (v & cmpc_pkg::CTL_WRITE_MASK) | {14'h0, v[11], 17'h0});
            check({comparator_enable, negative_input_select, positive_input_select, positive_offset_select,
                hysteresis_level}, {v[0], v[1], v[2], v[4:3], v[13:12]});
        end
        check(irq_request, 1'h0);
        analog_compare_out <= 1'h1;
        for (int c = 0; c < 8; c++) begin
            wr(8'h10, 32'(c) << 7);
            check({advanced_timer_break_input, advanced_timer_capture_one, advanced_timer_ref_clear,
                general_timer_capture_one, general_timer_ref_clear}, (c > 0 && c < 6) ? 5'h10 >> (c - 1) : 5'h0);
        end
        wr(8'h10, 32'h4080);
        advanced_timer_blank <= 1'h1;
        @(posedge mclk);
        check(advanced_timer_break_input, 1'h0);
        advanced_timer_blank <= 1'h0;
        analog_compare_out <= 1'h0;
        // interrupt flag: set on rising output, kept by writing one, cleared by zero
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        check(irq_request, 1'h0);
        analog_compare_out <= 1'h1;
        repeat (3) @(posedge mclk);
        check(irq_request, 1'h1);
        wr(8'h04, 32'h1);
        rd(8'h04, 32'h1);
        wr(8'h00, 32'h0);
        check(irq_request, 1'h0);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h0);
        // filter: sample every 2 clocks, window of 4, threshold 3
        analog_compare_out <= 1'h0;
        wr(8'h18, 32'h1);
        wr(8'h14, 32'hc7);
        wr(8'h10, 32'h0);
        repeat (10) @(posedge mclk);
        analog_compare_out <= 1'h1;
        rd(8'h10, 32'h0);
        analog_compare_out <= 1'h0;
        repeat (12) @(posedge mclk);
        rd(8'h10, 32'h0);
        analog_compare_out <= 1'h1;
        repeat (20) @(posedge mclk);
        rd(8'h10, 32'h0002_0000);
        // lock freezes configuration and takes one write only
        wr(8'h0c, 32'h1);
        wr(8'h10, 32'h1);
        wr(8'h14, 32'h0);
        wr(8'h18, 32'h0);
        wr(8'h0c, 32'h0);
        rd(8'h10, 32'h0002_0000);
        rd(8'h14, 32'hc7);
        rd(8'h18, 32'h1);
        rd(8'h0c, 32'h1);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        wr(8'h0c, 32'h0);
        wr(8'h0c, 32'h1);
        wr(8'h10, 32'h1);
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'h0002_0001);
        check(comparator_enable, 1'h1);
        repeat (2) @(posedge mclk);
        end_of_test();
    end
endmodule
`default_nettype wire
